// ===== udh_engine.sv
// Purpose: host end of source-synchronous dma bursts on an ide channel
// Assumes: drive side keeps its own handshake; one channel
// Notes:   drive strobe is captured on link_clk
// Notes on behaviour
// - burst starts on request, ack when ready
// - chip selects idle, address low under ack
// - write: drop stop, await ready, then data
// - read: release bus, drop stop, assert ready
// - one word per strobe edge, both edges
// - static strobe pauses, toggling resumes
// - receiver pauses by negating ready
// - pause first, then stop, crc, ack
// - host stop answered by request drop
// - drive request drop answered by stop
// - strobe high, crc on bus, ack released
// - crc over every word under ack
// - drive compares crc and flags mismatch
// - read strobe pin: ready on reads, strobe writes
// - device ready pin: strobe reads, ready writes
`timescale 1ns/10ps
`default_nettype none
`include "udh_defines.svh"

module udh_engine (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                link_clk,
    input  wire logic                burst_enable,
    input  wire logic                read_dir,
    input  wire udh_pkg::udh_timing_s timing,
    input  wire udh_pkg::udh_term_s  term,
    input  wire logic                desc_empty,
    input  wire logic                wr_valid,
    input  wire logic [`UDH_DW-1:0]  wr_data,
    output var  logic                wr_ready,
    output var  logic                rd_valid,
    output var  logic [`UDH_DW-1:0]  rd_data,
    input  wire logic                rd_ready,
    output var  logic                burst_active,
    output var  logic                burst_done,
    input  wire logic                dmarq,
    output var  logic                channel_dma_ack_n,
    output var  logic                primary_write_strobe_n,
    output var  logic                primary_read_strobe_n,
    input  wire logic                primary_device_ready,
    output var  logic [1:0]          chip_select_n,
    output var  logic [2:0]          dev_addr,
    input  wire logic [`UDH_DW-1:0]  dd_in,
    output var  logic [`UDH_DW-1:0]  dd_out,
    output var  logic                dd_oe
);

    udh_pkg::udh_state_e state_q;
    udh_pkg::udh_state_e state_d;
    logic                dir_q;
    logic                stop_q;
    logic                stop_d;
    logic                rs_q;
    logic                rs_d;
    logic                ack_n_d;
    logic                oe_d;
    logic                pend_q;
    logic [`UDH_CW-1:0]  cnt_q;
    logic                seen_q;
    logic                hold_q;
    logic                cap_q;
    logic [`UDH_DW-1:0]  crc_val;
    logic                dmarq_s;
    logic                rdy_s;
    logic                tgl_s;
    logic                term_any;
    logic                wr_take;
    logic                rd_new;
    logic                ct_ok;
    logic                rp_ok;
    logic                strb_st;
    logic                lstb_s;
    logic                lcap_s;
    logic                lack_s;
    logic                llvl_q;
    logic                ltgl_q;
    logic [`UDH_DW-1:0]  lword_q;
    logic [`UDH_DW-1:0]  dd1_q;
    logic [`UDH_DW-1:0]  dd2_q;

    function automatic logic in_burst(udh_pkg::udh_state_e s);
        in_burst = (s == udh_pkg::UDH_XFER) || (s == udh_pkg::UDH_HSTOP)
                || (s == udh_pkg::UDH_STRB);
    endfunction

    // drive side pins and the link word toggle into clk
    udh_sync3 #(.W(`UDH_SYNC_W)) u_core_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({dmarq, primary_device_ready, ltgl_q}),
        .q     ({dmarq_s, rdy_s, tgl_s})
    );

    // drive strobe pin and levels from clk into link_clk
    udh_sync3 #(.W(`UDH_SYNC_W)) u_link_sync (
        .clk   (link_clk),
        .rst_n (rst_n),
        .d     ({primary_device_ready, cap_q, seen_q}),
        .q     ({lstb_s, lcap_s, lack_s})
    );

    udh_crc16 u_crc (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (state_q == udh_pkg::UDH_IDLE),
        .en    (wr_take || rd_new),
        .data  (wr_take ? wr_data : lword_q),
        .crc   (crc_val)
    );

    assign term_any = term.other_channel || term.pio_access
                   || term.final_done;
    assign ct_ok    = cnt_q >= timing.strobe_cycle_time;
    assign rp_ok    = cnt_q >= timing.ready_to_pause_delay;
    // static strobe pauses the write burst
    assign wr_take  = (state_q == udh_pkg::UDH_XFER) && !dir_q && !pend_q
                   && !term_any && !desc_empty && !rdy_s && dmarq_s
                   && ct_ok && wr_valid;
    assign wr_ready = wr_take;
    assign rd_new   = dir_q && (tgl_s != seen_q) && !hold_q
                   && in_burst(state_q);
    // pause reached before a host stop
    assign strb_st  = dir_q ? (rs_q && rp_ok) : (!pend_q && ct_ok);

    // burst sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            udh_pkg::UDH_IDLE: begin
                if (burst_enable && dmarq_s && !term_any && !desc_empty) begin
                    state_d = udh_pkg::UDH_SETUP;
                end
            end
            udh_pkg::UDH_SETUP: begin
                if (dir_q || (!rdy_s && ct_ok)) begin
                    state_d = udh_pkg::UDH_XFER;
                end
            end
            udh_pkg::UDH_XFER: begin
                if (!dmarq_s && !pend_q) begin
                    state_d = udh_pkg::UDH_STRB;
                end else if (term_any && strb_st) begin
                    state_d = udh_pkg::UDH_HSTOP;
                end
            end
            udh_pkg::UDH_HSTOP: begin
                if (!dmarq_s) begin
                    state_d = udh_pkg::UDH_STRB;
                end
            end
            udh_pkg::UDH_STRB: begin
                if (dir_q ? (rdy_s && tgl_s == seen_q) : (rs_q && ct_ok)) begin
                    state_d = udh_pkg::UDH_CRC;
                end
            end
            udh_pkg::UDH_CRC: begin
                if (ct_ok) begin
                    state_d = udh_pkg::UDH_DONE;
                end
            end
            udh_pkg::UDH_DONE: begin
                if (ct_ok) begin
                    state_d = udh_pkg::UDH_IDLE;
                end
            end
            default: begin
                state_d = udh_pkg::UDH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= udh_pkg::UDH_IDLE;
            dir_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == udh_pkg::UDH_IDLE) begin
                dir_q <= read_dir;
            end
        end
    end

    // read strobe pin: strobe on writes, ready on reads
    always_comb begin
        rs_d = 1'b1;
        case (state_d)
            udh_pkg::UDH_SETUP: begin
                rs_d = !dir_q ? 1'b1 : 1'b0;
            end
            udh_pkg::UDH_XFER: begin
                if (!dir_q) begin
                    rs_d = pend_q ? !rs_q : rs_q;
                end else begin
                    rs_d = hold_q || desc_empty || term_any
                        || (tgl_s != seen_q);
                end
            end
            udh_pkg::UDH_HSTOP: begin
                rs_d = dir_q ? 1'b1 : rs_q;
            end
            default: begin
                rs_d = 1'b1;
            end
        endcase
    end

    assign stop_d  = !(state_d == udh_pkg::UDH_SETUP
                    || state_d == udh_pkg::UDH_XFER);
    assign ack_n_d = (state_d == udh_pkg::UDH_IDLE)
                  || (state_d == udh_pkg::UDH_DONE);
    assign oe_d    = (state_d == udh_pkg::UDH_CRC)
                  || (state_d == udh_pkg::UDH_DONE)
                  || (!dir_q && (state_d == udh_pkg::UDH_SETUP
                  || in_burst(state_d)));

    // cable pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q            <= 1'b1;
            rs_q              <= 1'b1;
            channel_dma_ack_n <= 1'b1;
            dd_oe             <= 1'b0;
            dd_out            <= '0;
            pend_q            <= 1'b0;
        end else begin
            stop_q            <= stop_d;
            rs_q              <= rs_d;
            channel_dma_ack_n <= ack_n_d;
            dd_oe             <= oe_d;
            pend_q            <= wr_take;
            if (wr_take) begin
                dd_out <= wr_data;
            end else if (state_d == udh_pkg::UDH_CRC) begin
                dd_out <= crc_val;
            end
        end
    end

    assign primary_write_strobe_n = stop_q;
    assign primary_read_strobe_n  = rs_q;
    assign chip_select_n          = `UDH_CS_IDLE;
    assign dev_addr               = `UDH_DA_IDLE;
    assign burst_active           = !channel_dma_ack_n;

    // cycles since the last state or read strobe change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (state_d != state_q || rs_d != rs_q) begin
            cnt_q <= '0;
        end else if (cnt_q != `UDH_CNT_MAX) begin
            cnt_q <= cnt_q + `UDH_CNT_ONE;
        end
    end

    // read words handed to the user
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q     <= 1'b0;
            hold_q     <= 1'b0;
            rd_data    <= '0;
            cap_q      <= 1'b0;
            burst_done <= 1'b0;
        end else begin
            cap_q      <= dir_q && (state_q == udh_pkg::UDH_SETUP
                       || state_q == udh_pkg::UDH_XFER
                       || state_q == udh_pkg::UDH_HSTOP);
            burst_done <= (state_q == udh_pkg::UDH_DONE)
                       && (state_d == udh_pkg::UDH_IDLE);
            if (rd_new) begin
                seen_q  <= tgl_s;
                hold_q  <= 1'b1;
                rd_data <= lword_q;
            end else if (rd_ready) begin
                hold_q  <= 1'b0;
            end
        end
    end

    assign rd_valid = hold_q;

    // link side: take a word on each drive strobe edge
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            dd1_q   <= '0;
            dd2_q   <= '0;
            llvl_q  <= 1'b0;
            ltgl_q  <= 1'b0;
            lword_q <= '0;
        end else begin
            dd1_q <= dd_in;
            dd2_q <= dd1_q;
            if (!lcap_s) begin
                llvl_q <= lstb_s;
            end else if (lstb_s != llvl_q && ltgl_q == lack_s) begin
                lword_q <= dd2_q;
                ltgl_q  <= !ltgl_q;
                llvl_q  <= lstb_s;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ack_after_req: assert property (
        $fell(channel_dma_ack_n) |-> $past(dmarq_s) && !$past(term_any))
        else $error("ack without drive request");
    a_cs_quiet: assert property (
        !channel_dma_ack_n |-> chip_select_n == 2'h3 && dev_addr == 3'h0)
        else $error("chip select active under ack");
    a_wr_ready_seen: assert property (
        (state_q == udh_pkg::UDH_XFER && !dir_q && $changed(rs_q))
        |-> $past(!rdy_s, 2) && $past(wr_valid, 2))
        else $error("write strobe without drive ready");
    a_rd_released: assert property (
        (dir_q && !channel_dma_ack_n && state_q != udh_pkg::UDH_CRC)
        |-> !dd_oe)
        else $error("bus driven during read");
    a_strobe_width: assert property (
        (state_q == udh_pkg::UDH_XFER && !dir_q && $changed(rs_q))
        |-> $past(cnt_q, 2) >= $past(timing.strobe_cycle_time, 2))
        else $error("strobe level shorter than cycle time");
    a_rp_wait: assert property (
        ($rose(stop_q) && state_q == udh_pkg::UDH_HSTOP && dir_q)
        |-> $past(rs_q) && $past(cnt_q) >= $past(timing.ready_to_pause_delay))
        else $error("stop before ready-to-pause delay");
    a_drive_stop_ack: assert property (
        (state_q == udh_pkg::UDH_XFER && !dmarq_s && !pend_q)
        |=> stop_q ##1 stop_q)
        else $error("drive stop not acknowledged");
    a_host_stop_hold: assert property (
        (state_q == udh_pkg::UDH_HSTOP) |-> stop_q [*2])
        else $error("stop dropped before request fell");
    a_crc_on_ack: assert property (
        $rose(channel_dma_ack_n) |-> dd_oe && dd_out == crc_val && rs_q)
        else $error("crc not on bus at ack release");
    a_desc_pause: assert property (
        (desc_empty && state_q == udh_pkg::UDH_XFER)
        |-> !wr_ready ##1 (!dir_q || primary_read_strobe_n))
        else $error("transfer while descriptor empty");
    a_rd_overflow: assert property (
        (rd_valid && !rd_ready && dir_q && state_q == udh_pkg::UDH_XFER)
        |=> primary_read_strobe_n)
        else $error("ready held with full line buffer");

    c_write_burst: cover property (
        !dir_q && $rose(channel_dma_ack_n));
    c_read_burst: cover property (
        dir_q && $rose(channel_dma_ack_n));
    c_drive_stop: cover property (
        state_q == udh_pkg::UDH_XFER ##1 state_q == udh_pkg::UDH_STRB);

endmodule

`default_nettype wire

// ===== udh_defines.svh
// Purpose: shared constants of the synchronous dma burst engine
// Assumes: included by bare name
// Notes:   counts are in clk cycles
`ifndef UDH_DEFINES_SVH
`define UDH_DEFINES_SVH

`define UDH_DW        16
`define UDH_CW        8
`define UDH_CNT_MAX   8'hFF
`define UDH_CNT_ONE   8'h01
`define UDH_CRC_SEED  16'h4ABA
`define UDH_CRC_POLY  16'h1021
`define UDH_SYNC_W    3
`define UDH_CS_IDLE   2'h3
`define UDH_DA_IDLE   3'h0

`endif

// ===== udh_pkg.sv
// Purpose: types of the synchronous dma burst engine
// Assumes: udh_defines.svh on the include path
// Notes:   state codes follow a gray path
`include "udh_defines.svh"

package udh_pkg;

    typedef enum logic [2:0] {
        UDH_IDLE  = 3'h0,
        UDH_SETUP = 3'h1,
        UDH_XFER  = 3'h3,
        UDH_HSTOP = 3'h2,
        UDH_STRB  = 3'h6,
        UDH_CRC   = 3'h7,
        UDH_DONE  = 3'h5
    } udh_state_e;

    typedef struct packed {
        logic [`UDH_CW-1:0] strobe_cycle_time;
        logic [`UDH_CW-1:0] ready_to_pause_delay;
    } udh_timing_s;

    typedef struct packed {
        logic other_channel;
        logic pio_access;
        logic final_done;
    } udh_term_s;

endpackage

// ===== udh_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: each bit is an independent level
// Notes:   output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module udh_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== udh_crc16.sv
// Purpose: crc-16 over burst words
// Assumes: one word per enable
// Notes:   msb first, generator x^16+x^12+x^5+1
`timescale 1ns/10ps
`default_nettype none
`include "udh_defines.svh"

module udh_crc16 (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clear,
    input  wire logic              en,
    input  wire logic [`UDH_DW-1:0] data,
    output var  logic [`UDH_DW-1:0] crc
);

    logic [`UDH_DW-1:0] crc_d;
    logic               fb;

    always_comb begin
        crc_d = crc;
        fb    = 1'b0;
        for (int i = `UDH_DW - 1; i >= 0; i--) begin
            fb    = crc_d[15] ^ data[i];
            crc_d = {crc_d[14:0], 1'b0} ^ (fb ? `UDH_CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= `UDH_CRC_SEED;
        end else if (clear) begin
            crc <= `UDH_CRC_SEED;
        end else if (en) begin
            crc <= crc_d;
        end
    end

endmodule

`default_nettype wire

// ===== udh_drive_model.sv
// Purpose: behavioural ide drive for synchronous dma bursts
// Assumes: lclk is the bench link clock, unrelated to clk
// Notes:   bench fills tx_q and reads rx_q and the crc counters
`timescale 1ns/10ps
`default_nettype none
`include "udh_defines.svh"

module udh_drive_model (
    input  wire logic               lclk,
    input  wire logic               rst_n,
    input  wire logic               go,
    input  wire logic               rd,
    input  wire logic               pause,
    input  wire logic               dstop,
    input  wire logic               ack_n,
    input  wire logic               stop_pin,
    input  wire logic               hstrb,
    input  wire logic [`UDH_DW-1:0] dd_out,
    input  wire logic               dd_oe,
    output var  logic               dmarq,
    output var  logic               dstrb,
    output var  logic [`UDH_DW-1:0] dd_line
);
    logic [`UDH_DW-1:0] drv_q;
    logic [`UDH_DW-1:0] crc;
    logic               drv_oe;
    logic               ended;
    logic               owed;
    logic               staged;
    int                 gap;
    logic [`UDH_DW-1:0] tx_q[$];
    logic [`UDH_DW-1:0] rx_q[$];
    int                 crc_seen = 0;
    int                 crc_err  = 0;

    function automatic logic [`UDH_DW-1:0] step(
        input logic [`UDH_DW-1:0] c,
        input logic [`UDH_DW-1:0] d
    );
        for (int i = `UDH_DW-1; i >= 0; i--) begin
            c = {c[`UDH_DW-2:0], 1'b0}
                ^ ((c[`UDH_DW-1] ^ d[i]) ? `UDH_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    // a released bus shows the inverse of the drive's last word
    assign dd_line = dd_oe ? dd_out : (drv_oe ? drv_q : ~drv_q);

    always @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            dmarq  <= 1'b0;
            dstrb  <= 1'b1;
            drv_oe <= 1'b0;
            ended  <= 1'b0;
            owed   <= 1'b0;
            staged <= 1'b0;
            gap    <= 0;
        end else if (ack_n) begin
            dstrb  <= 1'b1;
            drv_oe <= 1'b0;
            owed   <= 1'b0;
            staged <= 1'b0;
            gap    <= 0;
            ended  <= ended & go;
            dmarq  <= go & ~ended;
        end else if (stop_pin || !dmarq) begin
            if (dmarq) begin
                dmarq <= 1'b0;
                ended <= 1'b1;
            end
            if (stop_pin) begin
                dstrb  <= 1'b1;
                drv_oe <= 1'b0;
            end
        end else if (dstop) begin
            if (!rd) dstrb <= 1'b1;
            gap <= gap + 1;
            if (gap >= 8) begin
                dmarq <= 1'b0;
                ended <= 1'b1;
            end
        end else if (!rd) begin
            dstrb <= pause;
        end else if (staged) begin
            dstrb  <= ~dstrb;
            staged <= 1'b0;
            owed   <= 1'b1;
            gap    <= 0;
        end else if (owed) begin
            gap <= gap + 1;
            if (hstrb || gap > 40) owed <= 1'b0;
        end else if (!pause && !hstrb && tx_q.size() > 0) begin
            drv_q  <= tx_q.pop_front();
            drv_oe <= 1'b1;
            staged <= 1'b1;
        end
    end

    always @(negedge ack_n) crc = `UDH_CRC_SEED;

    always @(hstrb)
        if (rst_n && ack_n === 1'b0 && stop_pin === 1'b0 && !rd && dd_oe) begin
            rx_q.push_back(dd_line);
            crc = step(crc, dd_line);
        end

    always @(dstrb)
        if (rst_n && ack_n === 1'b0 && stop_pin === 1'b0 && rd)
            crc = step(crc, drv_q);

    always @(posedge ack_n)
        if (rst_n) begin
            crc_seen++;
            if (dd_line !== crc) crc_err++;
        end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench of the burst engine against a drive model
// Assumes: drive model in udh_drive_model.sv
// Notes:   inputs change at the falling edge of clk
`timescale 1ns/10ps
`default_nettype none
`include "udh_defines.svh"

module testbench;
    localparam int CT = 3;
    localparam int RP = 5;
    logic clk, lclk, rst_n, burst_enable, read_dir, desc_empty, rd_ready;
    logic wr_valid = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    udh_pkg::udh_timing_s timing;
    udh_pkg::udh_term_s   term;
    logic [15:0] rd_data, dd_in, dd_out;
    logic wr_ready, rd_valid, burst_active, burst_done, dmarq, ack_n;
    logic stop_pin, hstrb, dstrb, dd_oe, go, pause, dstop, hq, sq, in_burst;
    logic [1:0] cs_n;
    logic [2:0] da;
    int failures = 0, checks = 0, idx = 0, nw = 0, done_n = 0, rn = 0;
    int w = 0, minw = 999, rpw = 0;
    logic [15:0] wq[$];
    logic [15:0] rq[$];

    udh_engine DUT (.clk(clk), .rst_n(rst_n), .link_clk(lclk),
        .burst_enable(burst_enable), .read_dir(read_dir), .timing(timing),
        .term(term), .desc_empty(desc_empty), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .burst_active(burst_active),
        .burst_done(burst_done), .dmarq(dmarq), .channel_dma_ack_n(ack_n),
        .primary_write_strobe_n(stop_pin), .primary_read_strobe_n(hstrb),
        .primary_device_ready(dstrb), .chip_select_n(cs_n), .dev_addr(da),
        .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));

    udh_drive_model DRV (.lclk(lclk), .rst_n(rst_n), .go(go),
        .rd(read_dir), .pause(pause), .dstop(dstop), .ack_n(ack_n),
        .stop_pin(stop_pin), .hstrb(hstrb), .dd_out(dd_out), .dd_oe(dd_oe),
        .dmarq(dmarq), .dstrb(dstrb), .dd_line(dd_in));

    assign in_burst = (ack_n === 1'b0);

    task automatic check(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_ge(input string n, input int lo, input int g);
        checks++;
        if (g < lo) begin
            failures++;
            $display("mismatch %s expected >= %0d seen %0d", n, lo, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_cnt(ref int v, input int t);
        int n;
        n = 0;
        while (v < t && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (v < t) begin
            failures++;
            $display("mismatch wait expected %0d seen %0d", t, v);
            conclude();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        lclk = 1'b0;
        #3;
        forever #15 lclk = ~lclk;
    end

    always @(negedge clk) begin
        wr_valid <= idx < nw;
        wr_data  <= (idx < nw) ? wq[idx] : 16'h0000;
    end

    always @(posedge clk) begin
        if (wr_valid && wr_ready) idx <= idx + 1;
        if (rd_valid && rd_ready) begin
            rq.push_back(rd_data);
            rn <= rn + 1;
        end
        if (burst_done === 1'b1) done_n <= done_n + 1;
        hq <= hstrb;
        sq <= stop_pin;
        w  <= (hstrb !== hq) ? 1 : w + 1;
        if (hstrb !== hq && in_burst && !read_dir && !stop_pin && w < minw)
            minw <= w;
        if (stop_pin && !sq && in_burst && read_dir) rpw <= w;
        if (in_burst) begin
            check("chip_select_n", 16'h0003, {14'h0, cs_n});
            check("dev_addr", 16'h0000, {13'h0, da});
            if (read_dir && !stop_pin)
                check("dd_oe on read", 16'h0000, {15'h0, dd_oe});
        end
    end

    task automatic t_write(input int k);
        int i0, s0, e0;
        @(negedge clk);
        read_dir = 1'b0;
        minw = 999;
        wq.delete();
        for (int i = 0; i < 6; i++)
            wq.push_back(16'(i * 16'h3333) ^ 16'(k * 16'h0101));
        DRV.rx_q.delete();
        s0 = DRV.crc_seen;
        e0 = DRV.crc_err;
        i0 = done_n;
        idx = 0;
        nw = 6;
        go = 1'b1;
        wait_cnt(idx, 2);
        desc_empty = 1'b1;
        repeat (6) @(negedge clk);
        i0 = idx;
        repeat (30) @(negedge clk);
        check("taken while exhausted", 16'(i0), 16'(idx));
        desc_empty = 1'b0;
        wait_cnt(idx, 4);
        pause = 1'b1;
        repeat (12) @(negedge clk);
        i0 = DRV.rx_q.size();
        repeat (30) @(negedge clk);
        check("sent while paused", 16'(i0), 16'(DRV.rx_q.size()));
        pause = 1'b0;
        wait_cnt(idx, 6);
        go = 1'b0;
        i0 = done_n;
        term = 3'(1 << k);
        wait_cnt(done_n, i0 + 1);
        term = '0;
        check("words written", 16'h0006, 16'(DRV.rx_q.size()));
        for (int i = 0; i < 6; i++)
            check("written word", wq[i], DRV.rx_q[i]);
        check("crc frames", 16'(s0 + 1), 16'(DRV.crc_seen));
        check("crc errors", 16'(e0), 16'(DRV.crc_err));
        check_ge("strobe level width", CT + 1, minw);
        $display("test write %0d done", k);
    endtask

    task automatic t_read(input logic hstop);
        int s0, e0, d0;
        logic [15:0] exp[$];
        @(negedge clk);
        read_dir = 1'b1;
        rq.delete();
        rn = 0;
        for (int i = 0; i < 5; i++) exp.push_back(16'(i * 16'h1F1F + 16'h8001));
        DRV.tx_q = exp;
        s0 = DRV.crc_seen;
        e0 = DRV.crc_err;
        d0 = done_n;
        go = 1'b1;
        wait_cnt(rn, 2);
        rd_ready = 1'b0;
        repeat (60) @(negedge clk);
        check("drive words left", 16'h0002, 16'(DRV.tx_q.size()));
        rd_ready = 1'b1;
        wait_cnt(rn, 5);
        go = 1'b0;
        if (hstop) term = 3'h2;
        else dstop = 1'b1;
        wait_cnt(done_n, d0 + 1);
        term = '0;
        dstop = 1'b0;
        for (int i = 0; i < 5; i++)
            check("read word", exp[i], rq[i]);
        check("crc frames", 16'(s0 + 1), 16'(DRV.crc_seen));
        check("crc errors", 16'(e0), 16'(DRV.crc_err));
        if (hstop) check_ge("ready to pause", RP, rpw);
        $display("test read %0d done", hstop);
    endtask

    initial begin
        rst_n = 1'b0;
        burst_enable = 1'b0;
        read_dir = 1'b0;
        desc_empty = 1'b0;
        rd_ready = 1'b1;
        timing = {8'(CT), 8'(RP)};
        term = '0;
        go = 1'b0;
        pause = 1'b0;
        dstop = 1'b0;
        repeat (8) @(posedge clk);
        check("pins in reset", 16'h001C,
              {11'h0, ack_n, stop_pin, hstrb, dd_oe, burst_active});
        @(negedge clk);
        rst_n = 1'b1;
        burst_enable = 1'b1;
        repeat (6) @(negedge clk);
        $display("test reset done");
        for (int k = 0; k < 3; k++) t_write(k);
        t_read(1'b0);
        t_read(1'b1);
        conclude();
    end
endmodule
`default_nettype wire
